/* File: phyvrb_pkg.sv */
/*
 * phyvrb_pkg: constants for the PHY vendor register bank.
 * Assumes a 16-bit management register port with 5-bit register indexes.
 */
// Operation
// - bit 2 crosses pairs 0/1 when auto off
// - bit 1 crosses pairs 2/3 when auto off
// - bit 0 limits parallel detect to advertised speeds
// - read trigger latches advanced register, then self-clears
// - seven-bit advanced register number, valid 0-12
// - read-only data port, resets to zero
// - delay enables kept across software reset
// - delay enables load from strap at reset
// - bit 4 reports 10BASE-T receive polarity
// - buffer overflow and underflow flags latch high
// - idle error overflow flag latches high
// - energy detect rising edge latches flag
// - autoneg complete and remote fault latch
// - link down latches flag bit 4
// - partner ack, detect fault, page received latch
// - each flag has a mask enable bit
// - advanced registers cannot be written
`default_nettype none
package phyvrb_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int ADV_N = 13;
    localparam int SEL_W = 7;
    localparam int FLAG_N = 10;
    localparam int MODE_W = 5;
    localparam int FIFO_W = 2;
    localparam int RSV_W = 8;
    localparam int BYTES_W = 3;
    // register indexes
    localparam logic [ADDR_W-1:0] OFS_EXT = 5'h13;
    localparam logic [ADDR_W-1:0] OFS_IAP = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_IRD = 5'h15;
    localparam logic [ADDR_W-1:0] OFS_DLY = 5'h1B;
    localparam logic [ADDR_W-1:0] OFS_FLG = 5'h1D;
    localparam logic [ADDR_W-1:0] OFS_MSK = 5'h1E;
    // field positions
    localparam int EXT_MODE_LSB = 11;
    localparam int EXT_FIFO_LSB = 9;
    localparam int EXT_MDI01 = 2;
    localparam int EXT_MDI23 = 1;
    localparam int EXT_CPD = 0;
    localparam int IAP_RD = 15;
    localparam int IAP_RSV_LSB = 7;
    localparam int IAP_SEL_LSB = 0;
    localparam int DLY_TX = 9;
    localparam int DLY_RX = 8;
    localparam int DLY_POL = 4;
    localparam int FLG_LSB = 1;
    // reset values and the last valid advanced register number
    localparam logic [FIFO_W-1:0] FIFO_RST = 2'h0;
    localparam logic [RSV_W-1:0] IAP_RSV_RST = 8'h03;
    localparam logic [SEL_W-1:0] SEL_RST = 7'h00;
    localparam logic [DATA_W-1:0] RD_RST = 16'h0000;
    localparam logic [FLAG_N-1:0] FLAG_RST = 10'h000;
    localparam logic [FLAG_N-1:0] MASK_RST = 10'h000;
    localparam logic [BYTES_W-1:0] FIFO_BASE = 3'h4;
    localparam logic [SEL_W-1:0] ADV_LAST = 7'h0C;
    // flag vector index (register bit = index + FLG_LSB)
    localparam int FI_ENERGY = 6;
endpackage
`default_nettype wire

/* File: phyvrb_core_if.sv */
/*
 * phyvrb_core_if: wires between the register bank and its flag and
 * advanced-port helpers. Assumes one clock shared by all three.
 */
`timescale 1ns/100ps
`default_nettype none
interface phyvrb_core_if;
    logic [phyvrb_pkg::FLAG_N-1:0] evt;
    logic [phyvrb_pkg::FLAG_N-1:0] clr;
    logic [phyvrb_pkg::FLAG_N-1:0] flag;
    logic adv_load;
    logic adv_clr;
    logic [phyvrb_pkg::SEL_W-1:0] adv_sel;
    logic [phyvrb_pkg::ADV_N-1:0][phyvrb_pkg::DATA_W-1:0] adv_src;
    logic [phyvrb_pkg::DATA_W-1:0] adv_data;
    modport flag_mp (input evt, input clr, output flag);
    modport adv_mp (input adv_load, input adv_clr, input adv_sel, input adv_src, output adv_data);
    modport ctl_mp (output evt, output clr, output adv_load, output adv_clr, output adv_sel,
        output adv_src, input flag, input adv_data);
endinterface
`default_nettype wire

/* File: phyvrb_flag_bank.sv */
/*
 * phyvrb_flag_bank: latched-high, write-clear interrupt source flags.
 * Assumes events are one-cycle pulses and clr is a one-cycle write mask.
 */
`timescale 1ns/100ps
`default_nettype none
module phyvrb_flag_bank (
    input wire logic ref_clk, // clock
    input wire logic srst, // sync reset, high
    phyvrb_core_if.flag_mp b // events, clears, flags
);
    typedef struct packed {
        logic [phyvrb_pkg::FLAG_N-1:0] flag;
    } phyvrb_flag_st_t;

    phyvrb_flag_st_t st_ff;
    phyvrb_flag_st_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        // a new event beats a clear in the same cycle
        nxt_st.flag = b.evt | (st_ff.flag & ~b.clr);
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_ff.flag <= phyvrb_pkg::FLAG_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign b.flag = st_ff.flag;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    flag_latch_a: assert property ((|b.evt) |=> ((b.flag & $past(b.evt)) == $past(b.evt)))
        else $error("event did not set its flag");
    flag_hold_a: assert property (((b.clr | b.evt) == '0) |=> b.flag == $past(b.flag))
        else $error("flag changed without event or clear");
endmodule
`default_nettype wire

/* File: phyvrb_adv_port.sv */
/*
 * phyvrb_adv_port: read-data latch for the advanced register bank.
 * Assumes adv_src holds the live advanced register contents.
 */
`timescale 1ns/100ps
`default_nettype none
module phyvrb_adv_port (
    input wire logic ref_clk, // clock
    input wire logic srst, // sync reset, high
    phyvrb_core_if.adv_mp b // load request and data
);
    typedef struct packed {
        logic [phyvrb_pkg::DATA_W-1:0] data;
    } phyvrb_adv_st_t;

    phyvrb_adv_st_t st_ff;
    phyvrb_adv_st_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (b.adv_clr)
        begin
            nxt_st.data = phyvrb_pkg::RD_RST;
        end
        else if (b.adv_load)
        begin
            // out-of-range numbers latch zero
            if (b.adv_sel <= phyvrb_pkg::ADV_LAST)
            begin
                nxt_st.data = b.adv_src[b.adv_sel[3:0]];
            end
            else
            begin
                nxt_st.data = phyvrb_pkg::RD_RST;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_ff.data <= phyvrb_pkg::RD_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign b.adv_data = st_ff.data;

    data_reset_a: assert property (@(posedge ref_clk) srst |=> b.adv_data == 16'h0000)
        else $error("read data not zero after reset");
endmodule
`default_nettype wire

/* File: phyvrb_top.sv */
/*
 * phyvrb_top: vendor register bank of a gigabit PHY - extended mode,
 * indirect advanced-register port, delay/polarity, interrupt flags and mask.
 * Assumes a management master on the plain register port: one-cycle strobes,
 * read data valid only in the cycle after the read strobe.
 */
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module phyvrb_top (
    input wire logic ref_clk, // 250 MHz clock
    input wire logic srst, // hardware reset, sync, high
    input wire logic soft_rst, // software reset pulse
    input wire logic [phyvrb_pkg::MODE_W-1:0] mode_pins, // mode configuration pins
    input wire logic delay_strap, // internal delay strap level
    input wire logic [phyvrb_pkg::ADDR_W-1:0] reg_addr, // register index
    input wire logic [phyvrb_pkg::DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [phyvrb_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after strobe
    input wire logic auto_mdix_off, // automatic crossover disabled
    input wire logic auto_cross_01, // automatic choice, pairs 0/1
    input wire logic auto_cross_23, // automatic choice, pairs 2/3
    input wire logic pd_at_100, // parallel detect sees 100 Mb/s
    input wire logic adv_10_hd, // 10 half duplex advertised
    input wire logic adv_100_hd, // 100 half duplex advertised
    input wire logic ten_base_polarity_flag, // 10BASE-T reversed polarity
    input wire logic [phyvrb_pkg::ADV_N-1:0][phyvrb_pkg::DATA_W-1:0] adv_regs, // advanced registers
    input wire logic tx_ovf_evt, // elastic buffer overflow pulse
    input wire logic tx_unf_evt, // elastic buffer underflow pulse
    input wire logic idle_ovf_evt, // idle error counter overflow pulse
    input wire logic energy_detect, // energy detect level
    input wire logic an_done_evt, // autoneg complete pulse
    input wire logic rem_fault_evt, // remote fault pulse
    input wire logic link_down_evt, // link lost pulse
    input wire logic lp_ack_evt, // partner acknowledge pulse
    input wire logic pd_fault_evt, // detect or config fault pulse
    input wire logic page_rx_evt, // page received pulse
    output logic [phyvrb_pkg::MODE_W-1:0] operating_mode_field, // operating mode
    output logic [phyvrb_pkg::BYTES_W-1:0] tx_fifo_bytes, // transmit FIFO depth, bytes
    output logic pair01_cross, // pairs 0/1 crossed
    output logic pair23_cross, // pairs 2/3 crossed
    output logic pd_allow, // parallel detect permitted
    output logic tx_delay_en, // transmit clock delay on
    output logic rx_delay_en, // receive clock delay on
    output logic irq // interrupt, high
);
    typedef struct packed {
        logic [phyvrb_pkg::MODE_W-1:0] mode;
        logic [phyvrb_pkg::FIFO_W-1:0] fifo;
        logic mdi01;
        logic mdi23;
        logic cpd;
        logic [phyvrb_pkg::RSV_W-1:0] rsv;
        logic [phyvrb_pkg::SEL_W-1:0] sel;
        logic dtx;
        logic drx;
        logic [phyvrb_pkg::FLAG_N-1:0] mask;
        logic energy_q;
        logic [phyvrb_pkg::DATA_W-1:0] rdata;
        logic [phyvrb_pkg::BYTES_W-1:0] fbytes;
        logic p01;
        logic p23;
        logic pda;
        logic irq;
    } phyvrb_top_st_t;

    phyvrb_top_st_t st_ff;
    phyvrb_top_st_t nxt_st;
    logic [phyvrb_pkg::DATA_W-1:0] rd_val;
    logic ext_wr_now;

    phyvrb_core_if cif ();

    phyvrb_flag_bank u_flags (
        .ref_clk(ref_clk),
        .srst(srst),
        .b(cif.flag_mp)
    );

    phyvrb_adv_port u_adv (
        .ref_clk(ref_clk),
        .srst(srst),
        .b(cif.adv_mp)
    );

    // event vector, index i is flag register bit i+1
    assign cif.evt = {tx_ovf_evt, tx_unf_evt, idle_ovf_evt,
        energy_detect & ~st_ff.energy_q,
        an_done_evt, rem_fault_evt, link_down_evt, lp_ack_evt, pd_fault_evt, page_rx_evt};
    assign cif.adv_src = adv_regs;
    assign cif.adv_sel = reg_wdata[phyvrb_pkg::IAP_SEL_LSB +: phyvrb_pkg::SEL_W];
    assign ext_wr_now = reg_wr && reg_addr == phyvrb_pkg::OFS_EXT && !soft_rst;

    always_comb
    begin
        nxt_st = st_ff;
        rd_val = '0;
        cif.clr = '0;
        cif.adv_load = 1'b0;
        cif.adv_clr = soft_rst;
        nxt_st.energy_q = energy_detect;
        if (soft_rst)
        begin
            // mode and delay enables survive a software reset
            nxt_st.fifo = phyvrb_pkg::FIFO_RST;
            nxt_st.mdi01 = 1'b0;
            nxt_st.mdi23 = 1'b0;
            nxt_st.cpd = 1'b0;
            nxt_st.rsv = phyvrb_pkg::IAP_RSV_RST;
            nxt_st.sel = phyvrb_pkg::SEL_RST;
            nxt_st.mask = phyvrb_pkg::MASK_RST;
            cif.clr = '1;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                phyvrb_pkg::OFS_EXT:
                begin
                    nxt_st.mode = reg_wdata[phyvrb_pkg::EXT_MODE_LSB +: phyvrb_pkg::MODE_W];
                    nxt_st.fifo = reg_wdata[phyvrb_pkg::EXT_FIFO_LSB +: phyvrb_pkg::FIFO_W];
                    nxt_st.mdi01 = reg_wdata[phyvrb_pkg::EXT_MDI01];
                    nxt_st.mdi23 = reg_wdata[phyvrb_pkg::EXT_MDI23];
                    nxt_st.cpd = reg_wdata[phyvrb_pkg::EXT_CPD];
                end
                phyvrb_pkg::OFS_IAP:
                begin
                    nxt_st.rsv = reg_wdata[phyvrb_pkg::IAP_RSV_LSB +: phyvrb_pkg::RSV_W];
                    nxt_st.sel = cif.adv_sel;
                    cif.adv_load = reg_wdata[phyvrb_pkg::IAP_RD];
                end
                phyvrb_pkg::OFS_DLY:
                begin
                    nxt_st.dtx = reg_wdata[phyvrb_pkg::DLY_TX];
                    nxt_st.drx = reg_wdata[phyvrb_pkg::DLY_RX];
                end
                phyvrb_pkg::OFS_FLG:
                begin
                    cif.clr = reg_wdata[phyvrb_pkg::FLG_LSB +: phyvrb_pkg::FLAG_N];
                end
                phyvrb_pkg::OFS_MSK:
                begin
                    nxt_st.mask = reg_wdata[phyvrb_pkg::FLG_LSB +: phyvrb_pkg::FLAG_N];
                end
                // read data port and unmapped indexes ignore writes
                default:
                begin
                    nxt_st.rsv = st_ff.rsv;
                end
            endcase
        end
        // read mux; the trigger bit always reads back as zero
        case (reg_addr)
            phyvrb_pkg::OFS_EXT:
            begin
                rd_val[phyvrb_pkg::EXT_MODE_LSB +: phyvrb_pkg::MODE_W] = st_ff.mode;
                rd_val[phyvrb_pkg::EXT_FIFO_LSB +: phyvrb_pkg::FIFO_W] = st_ff.fifo;
                rd_val[phyvrb_pkg::EXT_MDI01] = st_ff.mdi01;
                rd_val[phyvrb_pkg::EXT_MDI23] = st_ff.mdi23;
                rd_val[phyvrb_pkg::EXT_CPD] = st_ff.cpd;
            end
            phyvrb_pkg::OFS_IAP:
            begin
                rd_val[phyvrb_pkg::IAP_RSV_LSB +: phyvrb_pkg::RSV_W] = st_ff.rsv;
                rd_val[phyvrb_pkg::IAP_SEL_LSB +: phyvrb_pkg::SEL_W] = st_ff.sel;
            end
            phyvrb_pkg::OFS_IRD:
            begin
                rd_val = cif.adv_data;
            end
            phyvrb_pkg::OFS_DLY:
            begin
                rd_val[phyvrb_pkg::DLY_TX] = st_ff.dtx;
                rd_val[phyvrb_pkg::DLY_RX] = st_ff.drx;
                rd_val[phyvrb_pkg::DLY_POL] = ten_base_polarity_flag;
            end
            phyvrb_pkg::OFS_FLG:
            begin
                rd_val[phyvrb_pkg::FLG_LSB +: phyvrb_pkg::FLAG_N] = cif.flag;
            end
            phyvrb_pkg::OFS_MSK:
            begin
                rd_val[phyvrb_pkg::FLG_LSB +: phyvrb_pkg::FLAG_N] = st_ff.mask;
            end
            default:
            begin
                rd_val = '0;
            end
        endcase
        nxt_st.rdata = reg_rd ? rd_val : '0;
        nxt_st.fbytes = phyvrb_pkg::FIFO_BASE + {1'b0, st_ff.fifo};
        nxt_st.p01 = auto_mdix_off ? st_ff.mdi01 : auto_cross_01;
        nxt_st.p23 = auto_mdix_off ? st_ff.mdi23 : auto_cross_23;
        nxt_st.pda = !st_ff.cpd || (pd_at_100 ? adv_100_hd : adv_10_hd);
        nxt_st.irq = |(cif.flag & st_ff.mask);
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_ff <= '0;
            st_ff.mode <= mode_pins;
            st_ff.fifo <= phyvrb_pkg::FIFO_RST;
            st_ff.rsv <= phyvrb_pkg::IAP_RSV_RST;
            st_ff.sel <= phyvrb_pkg::SEL_RST;
            st_ff.mask <= phyvrb_pkg::MASK_RST;
            st_ff.rdata <= phyvrb_pkg::RD_RST;
            st_ff.fbytes <= phyvrb_pkg::FIFO_BASE;
            st_ff.dtx <= delay_strap;
            st_ff.drx <= delay_strap;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign operating_mode_field = st_ff.mode;
    assign tx_fifo_bytes = st_ff.fbytes;
    assign pair01_cross = st_ff.p01;
    assign pair23_cross = st_ff.p23;
    assign pd_allow = st_ff.pda;
    assign tx_delay_en = st_ff.dtx;
    assign rx_delay_en = st_ff.drx;
    assign irq = st_ff.irq;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    sequence ext_wr_s;
        ext_wr_now;
    endsequence
    sequence trig_wr_s;
        reg_wr && !soft_rst && reg_addr == phyvrb_pkg::OFS_IAP && reg_wdata[phyvrb_pkg::IAP_RD];
    endsequence

    fifo_depth_a: assert property (ext_wr_s |=> ##1 tx_fifo_bytes == 3'h4 + {1'b0, $past(reg_wdata[10:9], 2)})
        else $error("fifo depth does not follow field");
    pair01_manual_a: assert property ((ext_wr_s ##1 auto_mdix_off) |=> pair01_cross == $past(reg_wdata[2], 2))
        else $error("pairs 0/1 ignore manual choice");
    pair23_manual_a: assert property ((ext_wr_s ##1 auto_mdix_off) |=> pair23_cross == $past(reg_wdata[1], 2))
        else $error("pairs 2/3 ignore manual choice");
    pd_plain_a: assert property ((ext_wr_s and !reg_wdata[0]) |=> ##1 pd_allow)
        else $error("parallel detect blocked while unconditional");
    adv_latch_a: assert property ((trig_wr_s and reg_wdata[6:0] <= 7'h0C)
        |=> cif.adv_data == $past(adv_regs[reg_wdata[3:0]]))
        else $error("advanced register not latched");
    trig_clear_a: assert property ((trig_wr_s ##1 reg_rd && reg_addr == phyvrb_pkg::OFS_IAP)
        |=> !reg_rdata[15] && reg_rdata[6:0] == $past(reg_wdata[6:0], 2))
        else $error("trigger bit not self-cleared or address lost");
    strap_load_a: assert property (@(posedge ref_clk) disable iff (1'b0)
        srst |=> tx_delay_en == $past(delay_strap) && rx_delay_en == $past(delay_strap))
        else $error("delay enables not loaded from strap");
    soft_keep_a: assert property ((soft_rst && !$past(reg_wr))
        |=> $stable(tx_delay_en) && $stable(rx_delay_en) && $stable(operating_mode_field))
        else $error("software reset disturbed kept fields");
    polarity_rd_a: assert property ((reg_rd && reg_addr == phyvrb_pkg::OFS_DLY)
        |=> reg_rdata[4] == $past(ten_base_polarity_flag))
        else $error("polarity status misreported");
    energy_rise_a: assert property (($rose(energy_detect) && !soft_rst) |=> cif.flag[6])
        else $error("energy detect rise not latched");
    irq_on_a: assert property ((|(cif.flag & st_ff.mask)) |=> irq)
        else $error("enabled flag gave no interrupt");
    irq_off_a: assert property (((cif.flag & st_ff.mask) == 10'h000) |=> !irq)
        else $error("masked flags raised interrupt");
    adv_nowrite_a: assert property ((reg_wr && !soft_rst && reg_addr == phyvrb_pkg::OFS_IRD)
        |=> $stable(cif.adv_data))
        else $error("write reached the read data port");
    rd_only_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
endmodule
`default_nettype wire

/* File: phyvrb_smc_model.sv */
/*
 * phyvrb_smc_model: management controller model on the register port.
 * Assumes one clock, one-cycle strobes and read data in the cycle after.
 */
`timescale 1ns/100ps
`default_nettype none
module phyvrb_smc_model (
    input wire logic ref_clk, // clock
    output logic [phyvrb_pkg::ADDR_W-1:0] reg_addr, // register index
    output logic [phyvrb_pkg::DATA_W-1:0] reg_wdata, // write data
    output logic reg_wr, // write strobe
    output logic reg_rd, // read strobe
    input wire logic [phyvrb_pkg::DATA_W-1:0] reg_rdata // read data
);
    initial
    begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // released bus shows the inverse of the last value
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask
    // mode field written back as read
    task automatic wr_ext(input logic [10:0] low);
        logic [15:0] v;
        rd(phyvrb_pkg::OFS_EXT, v);
        wr(phyvrb_pkg::OFS_EXT, {v[15:11], low});
    endtask
    // reserved field always written as 03h
    task automatic wr_iap(input logic trig, input logic [6:0] sel);
        wr(phyvrb_pkg::OFS_IAP, {trig, 8'h03, sel});
    endtask
endmodule
`default_nettype wire

/* File: phy_vendor_register_bank_tb_top.sv */
/*
 * phy_vendor_register_bank_tb_top: self-checking bench of the register bank.
 * Assumes the management model drives the register port.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module phy_vendor_register_bank_tb_top;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic soft_rst = 1'b0;
    logic [4:0] mode_pins = 5'h15;
    logic delay_strap = 1'b1;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic mdix_off = 1'b1;
    logic [1:0] auto_x = 2'b00;
    logic pd100 = 1'b1;
    logic [1:0] adv_hd = 2'b00;
    logic pol = 1'b0;
    logic [12:0][15:0] adv = '0;
    logic [10:1] ev = '0;
    logic energy = 1'b0;
    logic [4:0] mode_o;
    logic [2:0] fifo_o;
    logic x01, x23, pd_o, txd, rxd, irq;
    int err_total = 0;
    int checks_done = 0;
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    phyvrb_smc_model phyvrb_smc_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    phyvrb_top phyvrb_top_i (.ref_clk(ref_clk), .srst(srst), .soft_rst(soft_rst), .mode_pins(mode_pins),
        .delay_strap(delay_strap), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .auto_mdix_off(mdix_off), .auto_cross_01(auto_x[1]),
        .auto_cross_23(auto_x[0]), .pd_at_100(pd100), .adv_10_hd(adv_hd[1]), .adv_100_hd(adv_hd[0]),
        .ten_base_polarity_flag(pol), .adv_regs(adv), .tx_ovf_evt(ev[10]), .tx_unf_evt(ev[9]),
        .idle_ovf_evt(ev[8]), .energy_detect(energy), .an_done_evt(ev[6]), .rem_fault_evt(ev[5]),
        .link_down_evt(ev[4]), .lp_ack_evt(ev[3]), .pd_fault_evt(ev[2]), .page_rx_evt(ev[1]),
        .operating_mode_field(mode_o), .tx_fifo_bytes(fifo_o), .pair01_cross(x01), .pair23_cross(x23),
        .pd_allow(pd_o), .tx_delay_en(txd), .rx_delay_en(rxd), .irq(irq));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
        begin
            $display("Result: passed");
        end
        else
        begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic rchk(input string nm, input logic [4:0] a, input logic [15:0] e);
        logic [15:0] d;
        phyvrb_smc_model_i.rd(a, d);
        `CHK(nm, e, d)
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        report_and_stop();
    end
    initial
    begin
        for (int k = 0; k < 13; k++)
        begin
            adv[k] = 16'hA500 + 16'(k);
        end
        cyc(20);
        srst <= 1'b0;
        cyc(2);
        `CHK("mode", 5'h15, mode_o)
        `CHK("delays", 2'b11, {txd, rxd})
        `CHK("fifo", 3'h4, fifo_o)
        rchk("ext", 5'h13, 16'hA800);
        rchk("iap", 5'h14, 16'h0180);
        rchk("ird", 5'h15, 16'h0000);
        rchk("dly", 5'h1B, 16'h0300);
        phyvrb_smc_model_i.wr(5'h1D, 16'h0080);
        rchk("flags", 5'h1D, 16'h0000);
        rchk("unmapped", 5'h00, 16'h0000);
        for (int i = 0; i < 4; i++)
        begin
            phyvrb_smc_model_i.wr_ext({2'(i), 6'h00, 2'(i), 1'b1});
            cyc(3);
            `CHK("fifo", 3'(4 + i), fifo_o)
            `CHK("cross", 2'(i), {x01, x23})
            `CHK("pd", 1'b0, pd_o)
        end
        adv_hd <= 2'b01;
        mdix_off <= 1'b0;
        auto_x <= 2'b10;
        cyc(3);
        `CHK("cross auto", 2'b10, {x01, x23})
        `CHK("pd adv", 1'b1, pd_o)
        phyvrb_smc_model_i.wr_ext(11'h000);
        adv_hd <= 2'b00;
        cyc(3);
        `CHK("pd free", 1'b1, pd_o)
        `CHK("mode kept", 5'h15, mode_o)
        foreach (adv[k])
        begin
            phyvrb_smc_model_i.wr_iap(1'b1, 7'(k));
            rchk("adv", 5'h15, adv[k]);
        end
        // foreach walks the packed range from 12 down to 0, so entry 0 is latched last
        rchk("iap back", 5'h14, 16'h0180);
        phyvrb_smc_model_i.wr(5'h15, 16'h1234);
        rchk("ird ro", 5'h15, adv[0]);
        phyvrb_smc_model_i.wr_iap(1'b1, 7'h0D);
        rchk("adv high", 5'h15, 16'h0000);
        phyvrb_smc_model_i.wr(5'h1B, 16'h0100);
        pol <= 1'b1;
        cyc(3);
        `CHK("delays wr", 2'b01, {txd, rxd})
        soft_rst <= 1'b1;
        cyc(1);
        soft_rst <= 1'b0;
        cyc(3);
        `CHK("delays soft", 2'b01, {txd, rxd})
        rchk("dly pol", 5'h1B, 16'h0110);
        rchk("ird soft", 5'h15, 16'h0000);
        rchk("iap soft", 5'h14, 16'h0180);
        @(posedge ref_clk);
        ev <= 10'h3BF;
        energy <= 1'b1;
        @(posedge ref_clk);
        ev <= '0;
        cyc(3);
        rchk("flags set", 5'h1D, 16'h07FE);
        `CHK("irq masked", 1'b0, irq)
        phyvrb_smc_model_i.wr(5'h1E, 16'h0400);
        cyc(3);
        `CHK("irq on", 1'b1, irq)
        rchk("mask", 5'h1E, 16'h0400);
        phyvrb_smc_model_i.wr(5'h1D, 16'h0400);
        cyc(3);
        `CHK("irq off", 1'b0, irq)
        rchk("flags clr", 5'h1D, 16'h03FE);
        phyvrb_smc_model_i.wr(5'h1D, 16'h03FE);
        cyc(3);
        rchk("flags none", 5'h1D, 16'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
